// ---- rtl/dse_security_erase.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dse_consts.vh"
module dse_security_erase (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        powerOnRst,
    input  wire        cmdValid,
    input  wire [7:0]  cmdOpcode,
    input  wire        dataValid,
    input  wire [15:0] dataWord,
    input  wire        secEnabledIn,
    input  wire [15:0] userPwWord,
    input  wire [15:0] masterPwWord,
    input  wire [47:0] nativeMaxLba,
    input  wire        mediaReady,
    input  wire [15:0] eraseTimeUnits,
    output reg  [7:0]  pwWordIdx,
    output reg         mediaWrite,
    output reg  [47:0] mediaLba,
    output reg         mediaZeroFill,
    output reg         mediaVerify,
    output reg         defectListUpdate,
    output reg  [7:0]  statusReg,
    output reg  [7:0]  errorReg,
    output reg         cmdDone,
    output reg         secEnabled,
    output reg         frozen,
    output reg         eraseArmed,
    output reg         masterPwKeep,
    output reg  [15:0] identWord89
);
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_DATA  = 3'd1;
    localparam [2:0] ST_CHECK = 3'd2;
    localparam [2:0] ST_SWEEP = 3'd3;
    localparam [2:0] ST_DONE  = 3'd4;

    reg  [2:0]  state;
    reg  [7:0]  wordCount;
    reg         idMaster;
    reg         modeEnh;
    reg         wasArmed;
    reg         abortFlag;
    reg  [2:0]  next_state;
    wire        pwMatch;
    wire        pwWord;
    wire        lastWord;
    wire        abortNow;

    assign pwWord   = dataValid && wordCount >= `DSE_PW_FIRST
                      && wordCount <= `DSE_PW_LAST;
    assign lastWord = dataValid
                      && wordCount == `DSE_LAST_IDX;
    // Abort decision made in the check cycle itself
    assign abortNow = !wasArmed || modeEnh
                      || (!secEnabled && !idMaster)
                      || (secEnabled && !pwMatch);

    dse_pw_compare u_cmp (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .start      (state == ST_IDLE),
        .wordValid  (pwWord),
        .wordData   (dataWord),
        .storedWord (idMaster ? masterPwWord : userPwWord),
        .match      (pwMatch)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmdValid && cmdOpcode == `DSE_OP_ERASE && !frozen) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (lastWord) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                next_state = abortNow ? ST_DONE : ST_SWEEP;
            end
            ST_SWEEP: begin
                if (mediaReady && mediaLba == nativeMaxLba) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            wordCount <= 8'h00;
            idMaster <= 1'b0;
            modeEnh <= 1'b0;
            wasArmed <= 1'b0;
            abortFlag <= 1'b0;
            pwWordIdx <= 8'h00;
            mediaWrite <= 1'b0;
            mediaLba <= 48'h000000000000;
            mediaZeroFill <= 1'b1;
            mediaVerify <= 1'b0;
            defectListUpdate <= 1'b0;
            statusReg <= 8'h40;
            errorReg <= 8'h00;
            cmdDone <= 1'b0;
            eraseArmed <= 1'b0;
            masterPwKeep <= 1'b1;
            identWord89 <= `DSE_ERASE_TIME_DEF;
        end else begin
            state <= next_state;
            cmdDone <= 1'b0;
            mediaZeroFill <= 1'b1;
            mediaVerify <= 1'b0;
            defectListUpdate <= 1'b0;
            masterPwKeep <= 1'b1;
            identWord89 <= eraseTimeUnits;
            // Index of the stored word for the next incoming word
            if (state == ST_DATA && dataValid) begin
                pwWordIdx <= wordCount;
            end else begin
                pwWordIdx <= wordCount - 8'h01;
            end
            case (state)
                ST_IDLE: begin
                    if (cmdValid) begin
                        errorReg <= 8'h00;
                        if (cmdOpcode == `DSE_OP_ERASE && !frozen) begin
                            wasArmed <= eraseArmed;
                            eraseArmed <= 1'b0;
                            wordCount <= 8'h00;
                            abortFlag <= 1'b0;
                            statusReg <= 8'h48;
                        end else if (cmdValid) begin
                            cmdDone <= 1'b1;
                            eraseArmed <= cmdOpcode == `DSE_OP_PREPARE;
                            if (frozen && (cmdOpcode == `DSE_OP_ERASE
                                || cmdOpcode == `DSE_OP_SET_PW
                                || cmdOpcode == `DSE_OP_UNLOCK
                                || cmdOpcode == `DSE_OP_DISABLE_PW)) begin
                                errorReg <= 8'h04;
                                statusReg <= 8'h41;
                            end else begin
                                statusReg <= 8'h40;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (dataValid) begin
                        wordCount <= wordCount + 8'h01;
                        if (wordCount == 8'h00) begin
                            idMaster <= dataWord[`DSE_ID_BIT];
                            modeEnh <= dataWord[`DSE_MODE_BIT];
                        end
                    end
                    if (lastWord) begin
                        statusReg <= 8'h80;
                    end
                end
                ST_CHECK: begin
                    mediaLba <= 48'h000000000000;
                    if (abortNow) begin
                        abortFlag <= 1'b1;
                    end else begin
                        mediaWrite <= 1'b1;
                    end
                end
                ST_SWEEP: begin
                    if (mediaReady) begin
                        if (mediaLba == nativeMaxLba) begin
                            mediaWrite <= 1'b0;
                        end else begin
                            mediaLba <= mediaLba + 48'h000000000001;
                        end
                    end
                end
                ST_DONE: begin
                    cmdDone <= 1'b1;
                    if (abortFlag) begin
                        errorReg <= 8'h04;
                        statusReg <= 8'h41;
                    end else begin
                        statusReg <= 8'h40;
                    end
                end
                default: statusReg <= 8'h40;
            endcase
        end
    end

    // Security state; frozen survives sys_rst, cleared by power-on only
    always @(posedge clk) begin
        if (powerOnRst) begin
            frozen <= 1'b0;
            secEnabled <= 1'b0;
        end else begin
            if (state == ST_IDLE && cmdValid
                && cmdOpcode == `DSE_OP_FREEZE) begin
                frozen <= 1'b1;
            end
            if (state == ST_DONE && !abortFlag) begin
                secEnabled <= 1'b0;
            end else if (state == ST_IDLE && !cmdValid) begin
                secEnabled <= secEnabledIn;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dse_consts.vh ----
`ifndef DSE_CONSTS_VH
`define DSE_CONSTS_VH
`define DSE_OP_SET_PW      8'hF1
`define DSE_OP_UNLOCK      8'hF2
`define DSE_OP_PREPARE     8'hF3
`define DSE_OP_ERASE       8'hF4
`define DSE_OP_FREEZE      8'hF5
`define DSE_OP_DISABLE_PW  8'hF6
`define DSE_PW_WORDS       16
`define DSE_PARAM_WORDS    256
`define DSE_LAST_IDX       8'hFF
`define DSE_PW_FIRST       8'h01
`define DSE_PW_LAST        8'h10
`define DSE_ID_BIT         0
`define DSE_MODE_BIT       1
`define DSE_ERR_ABT_BIT    2
`define DSE_ST_BSY_BIT     7
`define DSE_ST_RDY_BIT     6
`define DSE_ST_DRQ_BIT     3
`define DSE_ST_ERR_BIT     0
`define DSE_LBA_W          48
`define DSE_ERASE_TIME_DEF 16'h0001
`endif

// ---- rtl/dse_pw_compare.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dse_consts.vh"
// Running compare of the 16 password words against one stored word each
module dse_pw_compare (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        start,
    input  wire        wordValid,
    input  wire [15:0] wordData,
    input  wire [15:0] storedWord,
    output reg         match
);
    always @(posedge clk) begin
        if (sys_rst || start) begin
            match <= 1'b1;
        end else if (wordValid && wordData != storedWord) begin
            match <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- test/dse_security_erase_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module dse_security_erase_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        powerOnRst,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdOpcode,
    input wire logic        mediaReady,
    input wire logic [47:0] nativeMaxLba,
    input wire logic        mediaWrite,
    input wire logic [47:0] mediaLba,
    input wire logic        mediaZeroFill,
    input wire logic        mediaVerify,
    input wire logic        defectListUpdate,
    input wire logic [7:0]  statusReg,
    input wire logic [7:0]  errorReg,
    input wire logic        cmdDone,
    input wire logic        frozen
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || powerOnRst);
    // Command accepted only when neither busy nor in the data phase
    wire take = cmdValid && !statusReg[7] && !statusReg[3];
    media_fill_a: assert property (mediaWrite |-> mediaZeroFill
        && !mediaVerify && !defectListUpdate) else $error("bad fill");
    freeze_now_a: assert property (take && cmdOpcode == 8'hF5
        |-> ##[1:2] frozen) else $error("no freeze");
    frozen_hold_a: assert property (frozen |=> frozen)
        else $error("frozen lost");
    sweep_start_a: assert property ($rose(mediaWrite)
        |-> mediaLba == 48'h0) else $error("bad first lba");
    sweep_step_a: assert property (mediaWrite && mediaReady
        && mediaLba != nativeMaxLba |=> mediaLba == $past(mediaLba) + 48'h1)
        else $error("bad lba step");
    sweep_end_a: assert property (mediaWrite && mediaReady
        && mediaLba == nativeMaxLba |-> ##[1:3] cmdDone)
        else $error("no end");
    frozen_reject_a: assert property (frozen && take
        && cmdOpcode == 8'hF4 |-> ##[1:2] cmdDone && errorReg == 8'h04)
        else $error("frozen erase ran");
    abort_flags_a: assert property (cmdDone && errorReg[2]
        |-> statusReg == 8'h41) else $error("bad abort status");
endmodule
bind dse_security_erase dse_security_erase_props u_props (.clk, .sys_rst,
    .powerOnRst, .cmdValid, .cmdOpcode, .mediaReady, .nativeMaxLba,
    .mediaWrite, .mediaLba, .mediaZeroFill, .mediaVerify, .defectListUpdate,
    .statusReg, .errorReg, .cmdDone, .frozen);
`default_nettype wire

// ---- test/dse_media_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dse_media_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        mediaWrite,
    input  wire logic [7:0]  pwWordIdx,
    output var  logic        mediaReady,
    output var  logic [15:0] userPwWord,
    output var  logic [15:0] masterPwWord
);
    logic stall = 1'b0;
    // Slow media accepts every other cycle
    always @(posedge clk) stall <= slow && !stall;
    always_comb begin
        mediaReady   = mediaWrite && !stall;
        userPwWord   = 16'hA500 + {8'h00, pwWordIdx};
        masterPwWord = 16'h5A00 + {8'h00, pwWordIdx};
    end
endmodule
`default_nettype wire

// ---- test/dse_security_erase_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module dse_security_erase_bench;
    logic        clk = 1'b0, sys_rst = 1'b1, powerOnRst = 1'b1, slow = 1'b0;
    logic        cmdValid = 1'b0, dataValid = 1'b0, secEnabledIn = 1'b1;
    logic [7:0]  cmdOpcode = 8'h00;
    logic [15:0] dataWord = 16'h0000;
    logic        doneSec;
    int          num_errors = 0, check_count = 0, writes = 0, k;
    wire logic [15:0] userPwWord, masterPwWord, identWord89;
    wire logic [47:0] mediaLba;
    wire logic [7:0]  pwWordIdx, statusReg, errorReg;
    wire logic        mediaReady, mediaWrite, mediaZeroFill, mediaVerify;
    wire logic        defectListUpdate, cmdDone, secEnabled, frozen;
    wire logic        eraseArmed, masterPwKeep;
    logic [7:0]  rejOps [4] = '{8'hF1, 8'hF2, 8'hF4, 8'hF6};
    always #4 clk = ~clk;
    always @(posedge clk) if (mediaWrite && mediaReady) writes <= writes + 1;
    dse_security_erase u_dut (.clk, .sys_rst, .powerOnRst, .cmdValid,
        .cmdOpcode, .dataValid, .dataWord, .secEnabledIn, .userPwWord,
        .masterPwWord, .nativeMaxLba(48'h000000000005), .mediaReady,
        .eraseTimeUnits(16'h0123), .pwWordIdx, .mediaWrite, .mediaLba,
        .mediaZeroFill, .mediaVerify, .defectListUpdate, .statusReg,
        .errorReg, .cmdDone, .secEnabled, .frozen, .eraseArmed,
        .masterPwKeep, .identWord89);
    dse_media_model u_media (.clk, .slow, .mediaWrite, .pwWordIdx,
        .mediaReady, .userPwWord, .masterPwWord);
    task automatic check(input logic [47:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, input logic [1:0] ctl,
                       input logic [15:0] pw);
        int i;
        @(negedge clk);
        cmdValid  = 1'b1;
        cmdOpcode = op;
        @(negedge clk);
        cmdValid = 1'b0;
        if (statusReg[3] === 1'b1) begin
            for (i = 0; i < 256; i++) begin
                dataValid = 1'b1;
                dataWord  = i == 0 ? {14'h0000, ctl}
                          : i < 17 ? pw + 16'(i - 1) : 16'h0000;
                @(negedge clk);
            end
            dataValid = 1'b0;
        end
        for (i = 0; cmdDone !== 1'b1; i++) begin
            if (i > 300) begin
                num_errors++;
                final_report();
            end
            @(negedge clk);
        end
        doneSec = secEnabled;
    endtask
    task automatic outcome(input logic abort, input int n);
        check(errorReg, {5'h00, abort, 2'h0});
        check(statusReg, {7'h20, abort});
        check(writes, n);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        sys_rst    = 1'b0;
        powerOnRst = 1'b0;
        check(statusReg, 8'h40);
        run(8'hF4, 2'b00, 16'hA500);
        outcome(1'b1, 0);
        check(identWord89, 16'h0123);
        check(masterPwKeep, 1'b1);
        run(8'hF3, 2'b00, 16'h0000);
        check(eraseArmed, 1'b1);
        run(8'hF4, 2'b00, 16'h1234);
        outcome(1'b1, 0);
        run(8'hF4, 2'b01, 16'h5A00);
        outcome(1'b1, 0);
        run(8'hF3, 2'b00, 16'h0000);
        run(8'hF4, 2'b11, 16'h5A00);
        outcome(1'b1, 0);
        slow = 1'b1;
        run(8'hF3, 2'b00, 16'h0000);
        run(8'hF4, 2'b01, 16'h5A00);
        outcome(1'b0, 6);
        check(doneSec, 1'b0);
        check(eraseArmed, 1'b0);
        secEnabledIn = 1'b0;
        run(8'hF3, 2'b00, 16'h0000);
        run(8'hF4, 2'b00, 16'hA500);
        outcome(1'b1, 6);
        run(8'hF3, 2'b00, 16'h0000);
        run(8'hF4, 2'b01, 16'h1234);
        outcome(1'b0, 12);
        run(8'hF3, 2'b00, 16'h0000);
        run(8'hF5, 2'b00, 16'h0000);
        check({frozen, eraseArmed, statusReg}, 10'h240);
        for (k = 0; k < 4; k++) begin
            run(rejOps[k], 2'b01, 16'h5A00);
            outcome(1'b1, 12);
        end
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        check(frozen, 1'b1);
        powerOnRst = 1'b1;
        @(negedge clk);
        powerOnRst = 1'b0;
        check(frozen, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
